// [hw/wake_input_detector.sv]
// Module: wake input detector with APB registers, cyclic sense timers and interrupt
`timescale 1ns/10ps
`default_nettype none
module wake_input_detector #(
   parameter int unsigned FILT_SHORT = wake_pkg::FILT_SHORT_CYC,
   parameter int unsigned FILT_LONG  = wake_pkg::FILT_LONG_CYC,
   parameter int unsigned PERIOD     = wake_pkg::TIMER_PERIOD_CYC,
   parameter int unsigned ON_TIME    = wake_pkg::TIMER_ON_CYC
) (
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic [2:0]  hv_wake_pin,
   input  wire logic [1:0]  alt_output_pins,
   // Device side
   output logic [2:0]       pull_up_en,
   output logic [2:0]       pull_down_en,
   output logic             wake_request,
   output logic             irq
);
   localparam int unsigned CNT_W = 14;
   localparam int unsigned TW    = 16;

   wake_pkg::apb_req_t req;
   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

   logic [2:0]  wake_enable_ctrl_reg;
   logic [5:0]  detect_ctrl_reg;
   logic [5:0]  bias_ctrl_reg;
   logic [1:0]  alt_en_reg;
   logic [1:0]  dev_mode_reg;
   logic [2:0]  wake_source_status_reg;
   logic [1:0]  alt_wake_source_status_reg;
   logic [2:0]  wake_pin_level_status_reg;
   logic [1:0]  irq_status_reg;
   logic [1:0]  irq_enable_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        wake_req_reg;
   logic        irq_reg;
   logic [2:0]  pu_reg;
   logic [2:0]  pd_reg;
   logic [TW-1:0] tmr1_reg;
   logic [TW-1:0] tmr2_reg;

   // Access phase, answered with registered pready in the second access cycle (one wait state)
   wire acc     = req.psel && req.penable && !pready_reg;
   wire wr      = acc && req.pwrite;
   wire rd      = acc && !req.pwrite;
   wire hit_en  = (req.paddr == wake_pkg::OFS_ENABLE_CTRL);
   wire hit_det = (req.paddr == wake_pkg::OFS_DETECT_CTRL);
   wire hit_bia = (req.paddr == wake_pkg::OFS_BIAS_CTRL);
   wire hit_src = (req.paddr == wake_pkg::OFS_SRC_STATUS);
   wire hit_alt = (req.paddr == wake_pkg::OFS_ALT_STATUS);
   wire hit_lvl = (req.paddr == wake_pkg::OFS_LEVEL_STATUS);
   wire hit_mod = (req.paddr == wake_pkg::OFS_MODE_CTRL);
   wire hit_ist = (req.paddr == wake_pkg::OFS_IRQ_STATUS);
   wire hit_icl = (req.paddr == wake_pkg::OFS_IRQ_CLEAR);
   wire hit_ien = (req.paddr == wake_pkg::OFS_IRQ_ENABLE);
   wire hit_scl = (req.paddr == wake_pkg::OFS_SRC_CLEAR);
   wire hit_any = hit_en | hit_det | hit_bia | hit_src | hit_alt | hit_lvl | hit_mod | hit_ist | hit_icl
                  | hit_ien | hit_scl;

   wire active_mode = (dev_mode_reg == wake_pkg::MODE_NORMAL) || (dev_mode_reg == wake_pkg::MODE_STOP);

   // Cyclic timers: on window is the first ON_TIME cycles of each period
   wire tmr1_on = (tmr1_reg < TW'(ON_TIME));
   wire tmr2_on = (tmr2_reg < TW'(ON_TIME));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr1_reg <= '0;
         tmr2_reg <= '0;
      end else begin
         tmr1_reg <= (tmr1_reg == TW'(PERIOD - 1)) ? '0 : tmr1_reg + TW'(1);
         tmr2_reg <= (tmr2_reg == TW'(2 * PERIOD - 1)) ? '0 : tmr2_reg + TW'(1);
      end
   end

   // Per-channel filters: three main pins, then two alternate pins
   logic [4:0] ch_pin;
   logic [4:0] ch_open;
   logic [4:0] ch_level;
   logic [4:0] ch_edge;
   logic [4:0] ch_cyclic;
   logic [4:0] ch_win;
   logic [CNT_W-1:0] ch_filt [0:4];
   assign ch_pin = {alt_output_pins, hv_wake_pin};

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_ch
         if (g < 3) begin : g_main
            wire [1:0] det = detect_ctrl_reg[2*g+1:2*g];
            assign ch_cyclic[g] = det[1];
            assign ch_win[g]    = det[0] ? tmr2_on : tmr1_on;
            assign ch_open[g]   = !ch_cyclic[g] || ch_win[g];
            assign ch_filt[g]   = (det == wake_pkg::DET_STATIC_LONG) ? CNT_W'(FILT_LONG)
                                                                     : CNT_W'(FILT_SHORT);
         end else begin : g_alt
            assign ch_cyclic[g] = 1'b0;
            assign ch_win[g]    = 1'b1;
            assign ch_open[g]   = alt_en_reg[g-3];
            assign ch_filt[g]   = CNT_W'(FILT_SHORT);
         end
         wake_filter #(.CNT_W(CNT_W)) u_filt (
            .pclk        (pclk),
            .presetn     (presetn),
            .pin_async   (ch_pin[g]),
            .sense_open  (ch_open[g]),
            .filt_cycles (ch_filt[g]),
            .level       (ch_level[g]),
            .edge_pulse  (ch_edge[g])
         );
      end
   endgenerate

   wire [2:0] main_evt = ch_edge[2:0] & wake_enable_ctrl_reg;
   wire [1:0] alt_evt  = ch_edge[4:3];
   wire       any_evt  = |main_evt || |alt_evt;
   wire [2:0] src_clr  = (wr && hit_scl) ? req.pwdata[2:0] : 3'h0;
   wire [1:0] alt_clr  = (wr && hit_scl) ? req.pwdata[4:3] : 2'h0;
   wire [1:0] irq_clr  = (wr && hit_icl) ? req.pwdata[1:0] : 2'h0;
   // Irq bit 0: wake event seen in Normal/Stop; bit 1: wake request issued
   wire [1:0] irq_evt  = {any_evt && !active_mode, any_evt && active_mode};

   // Auto bias follows the filtered level
   logic [2:0] pu_next;
   logic [2:0] pd_next;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         case (bias_ctrl_reg[2*i+:2])
            wake_pkg::BIAS_DOWN: begin
               pu_next[i] = 1'b0;
               pd_next[i] = 1'b1;
            end
            wake_pkg::BIAS_UP: begin
               pu_next[i] = 1'b1;
               pd_next[i] = 1'b0;
            end
            wake_pkg::BIAS_AUTO: begin
               pu_next[i] = ch_level[i];
               pd_next[i] = !ch_level[i];
            end
            default: begin
               pu_next[i] = 1'b0;
               pd_next[i] = 1'b0;
            end
         endcase
      end
   end

   logic [31:0] rd_next;
   assign rd_next = hit_en  ? {29'h0, wake_enable_ctrl_reg} :
                    hit_det ? {26'h0, detect_ctrl_reg} :
                    hit_bia ? {26'h0, bias_ctrl_reg} :
                    hit_src ? {29'h0, wake_source_status_reg} :
                    hit_alt ? {30'h0, alt_wake_source_status_reg} :
                    hit_lvl ? {29'h0, wake_pin_level_status_reg} :
                    hit_mod ? {28'h0, alt_en_reg, dev_mode_reg} :
                    hit_ist ? {30'h0, irq_status_reg} :
                    hit_ien ? {30'h0, irq_enable_reg} : 32'h0;

   // Control registers and bus answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_enable_ctrl_reg <= wake_pkg::RST_ENABLE;
         detect_ctrl_reg      <= wake_pkg::RST_DETECT;
         bias_ctrl_reg        <= wake_pkg::RST_BIAS;
         alt_en_reg           <= wake_pkg::RST_ALT_EN;
         dev_mode_reg         <= 2'h0;
         irq_enable_reg       <= 2'h0;
         prdata_reg           <= 32'h0;
         pready_reg           <= 1'b0;
         pslverr_reg          <= 1'b0;
      end else begin
         pready_reg  <= acc;
         pslverr_reg <= acc && !hit_any;
         prdata_reg  <= rd ? rd_next : 32'h0;
         if (wr && hit_en)  wake_enable_ctrl_reg <= req.pwdata[2:0];
         if (wr && hit_det) detect_ctrl_reg <= req.pwdata[5:0];
         if (wr && hit_bia) bias_ctrl_reg <= req.pwdata[5:0];
         if (wr && hit_mod) begin
            dev_mode_reg <= req.pwdata[1:0];
            alt_en_reg   <= req.pwdata[3:2];
         end
         if (wr && hit_ien) irq_enable_reg <= req.pwdata[1:0];
      end
   end

   // Status: a set in the same cycle as a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_source_status_reg     <= 3'h0;
         alt_wake_source_status_reg <= 2'h0;
         irq_status_reg             <= 2'h0;
         wake_pin_level_status_reg  <= 3'h0;
      end else begin
         wake_source_status_reg     <= (wake_source_status_reg & ~src_clr) | main_evt;
         alt_wake_source_status_reg <= (alt_wake_source_status_reg & ~alt_clr) | alt_evt;
         irq_status_reg             <= (irq_status_reg & ~irq_clr) | irq_evt;
         for (int i = 0; i < 3; i++) begin
            // Cyclic pins keep the last in-window level; wake enable is not consulted
            if (active_mode && (!ch_cyclic[i] || ch_win[i]))
               wake_pin_level_status_reg[i] <= ch_level[i];
         end
      end
   end

   // Outputs
   wire irq_any = |(irq_status_reg & irq_enable_reg);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg      <= 1'b0;
         wake_req_reg <= 1'b0;
         pu_reg       <= 3'h0;
         pd_reg       <= 3'h0;
      end else begin
         irq_reg      <= irq_any;
         wake_req_reg <= irq_status_reg[1];
         pu_reg       <= pu_next;
         pd_reg       <= pd_next;
      end
   end

   assign prdata       = prdata_reg;
   assign pready       = pready_reg;
   assign pslverr      = pslverr_reg;
   assign irq          = irq_reg;
   assign wake_request = wake_req_reg;
   assign pull_up_en   = pu_reg;
   assign pull_down_en = pd_reg;

   // Checks
   property p_src_set;
      @(posedge pclk) disable iff (!presetn) main_evt[0] |=> wake_source_status_reg[0];
   endproperty
   a_src_set: assert property (p_src_set) else $error("source flag not set");

   property p_src_sticky;
      @(posedge pclk) disable iff (!presetn)
         (wake_source_status_reg[1] && !src_clr[1]) |=> wake_source_status_reg[1];
   endproperty
   a_src_sticky: assert property (p_src_sticky) else $error("source flag lost");

   property p_disabled;
      @(posedge pclk) disable iff (!presetn)
         (!wake_enable_ctrl_reg[2] && !wake_source_status_reg[2]) ##1 !wake_enable_ctrl_reg[2]
         |-> !wake_source_status_reg[2];
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled pin set flag");

   property p_irq_mode;
      @(posedge pclk) disable iff (!presetn) (any_evt && active_mode) |=> irq_status_reg[0];
   endproperty
   a_irq_mode: assert property (p_irq_mode) else $error("no irq event in active mode");

   property p_wake_req;
      @(posedge pclk) disable iff (!presetn) (any_evt && !active_mode) |-> ##2 wake_request;
   endproperty
   a_wake_req: assert property (p_wake_req) else $error("no wake request");

   property p_cyclic_gate;
      @(posedge pclk) disable iff (!presetn) (ch_cyclic[0] && !ch_win[0]) |-> !ch_open[0];
   endproperty
   a_cyclic_gate: assert property (p_cyclic_gate) else $error("cyclic pin open outside window");

   property p_static_open;
      @(posedge pclk) disable iff (!presetn) !ch_cyclic[1] |-> ch_open[1];
   endproperty
   a_static_open: assert property (p_static_open) else $error("static pin gated");

   property p_level_hold;
      @(posedge pclk) disable iff (!presetn)
         (ch_cyclic[0] && !ch_win[0]) |=> $stable(wake_pin_level_status_reg[0]);
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level changed outside window");

   property p_level_track;
      @(posedge pclk) disable iff (!presetn)
         (active_mode && !ch_cyclic[2]) |=> (wake_pin_level_status_reg[2] == $past(ch_level[2]));
   endproperty
   a_level_track: assert property (p_level_track) else $error("level status stale");

   property p_bias_auto;
      @(posedge pclk) disable iff (!presetn)
         (bias_ctrl_reg[1:0] == 2'b11) |=> (pull_up_en[0] == $past(ch_level[0])) && (pull_down_en[0] != pull_up_en[0]);
   endproperty
   a_bias_auto: assert property (p_bias_auto) else $error("auto bias wrong");

   property p_filt_sel;
      @(posedge pclk) disable iff (!presetn)
         (detect_ctrl_reg[1:0] == 2'b01) |-> (ch_filt[0] == CNT_W'(FILT_LONG));
   endproperty
   a_filt_sel: assert property (p_filt_sel) else $error("long filter not selected");

   property p_alt_filt;
      @(posedge pclk) disable iff (!presetn) alt_evt[0] |=> alt_wake_source_status_reg[0];
   endproperty
   a_alt_filt: assert property (p_alt_filt) else $error("alt flag not set");

   property p_edge_level;
      @(posedge pclk) disable iff (!presetn) 1'h1 |-> ((ch_level[0] != $past(ch_level[0])) == ch_edge[0]);
   endproperty
   a_edge_level: assert property (p_edge_level) else $error("level change without wake edge");

   property p_timer_two;
      @(posedge pclk) disable iff (!presetn) (detect_ctrl_reg[3:2] == 2'h3) |-> (ch_win[1] == tmr2_on);
   endproperty
   a_timer_two: assert property (p_timer_two) else $error("cyclic pin not on timer two");

   property p_irq_out;
      @(posedge pclk) disable iff (!presetn) 1'h1 |=> (irq == $past(irq_any));
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("interrupt output does not follow enabled status");
endmodule : wake_input_detector
`default_nettype wire

// [hw/wake_pkg.sv]
// Package: register map, field codes and timing constants of the wake input detector
package wake_pkg;
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned FILT_SHORT_US     = 16;
   localparam int unsigned FILT_LONG_US      = 64;
   localparam int unsigned FILT_SHORT_CYC    = FILT_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FILT_LONG_CYC     = FILT_LONG_US * (CLK_HZ / 1_000_000);
   localparam int unsigned NUM_WAKE          = 3;
   localparam int unsigned NUM_ALT           = 2;
   localparam int unsigned NUM_CH            = NUM_WAKE + NUM_ALT;
   localparam int unsigned TIMER_PERIOD_CYC  = 10000;
   localparam int unsigned TIMER_ON_CYC      = 2000;

   // Register byte offsets
   localparam logic [11:0] OFS_ENABLE_CTRL   = 12'h000;
   localparam logic [11:0] OFS_DETECT_CTRL   = 12'h004;
   localparam logic [11:0] OFS_BIAS_CTRL     = 12'h008;
   localparam logic [11:0] OFS_SRC_STATUS    = 12'h00C;
   localparam logic [11:0] OFS_ALT_STATUS    = 12'h010;
   localparam logic [11:0] OFS_LEVEL_STATUS  = 12'h014;
   localparam logic [11:0] OFS_MODE_CTRL     = 12'h018;
   localparam logic [11:0] OFS_IRQ_STATUS    = 12'h01C;
   localparam logic [11:0] OFS_IRQ_CLEAR     = 12'h020;
   localparam logic [11:0] OFS_IRQ_ENABLE    = 12'h024;
   localparam logic [11:0] OFS_SRC_CLEAR     = 12'h028;

   // Reset values
   localparam logic [2:0]  RST_ENABLE        = 3'h0;
   localparam logic [5:0]  RST_DETECT        = 6'h00;
   localparam logic [5:0]  RST_BIAS          = 6'h00;
   localparam logic [1:0]  RST_ALT_EN        = 2'h0;

   typedef enum logic [1:0] {
      DET_STATIC_SHORT = 2'b00,
      DET_STATIC_LONG  = 2'b01,
      DET_CYCLIC_ONE   = 2'b10,
      DET_CYCLIC_TWO   = 2'b11
   } detect_mode_field_t;

   typedef enum logic [1:0] {
      BIAS_NONE = 2'b00,
      BIAS_DOWN = 2'b01,
      BIAS_UP   = 2'b10,
      BIAS_AUTO = 2'b11
   } bias_source_field_t;

   typedef enum logic [1:0] {
      MODE_NORMAL    = 2'b00,
      MODE_STOP      = 2'b01,
      MODE_SLEEP     = 2'b10,
      MODE_FAIL_SAFE = 2'b11
   } dev_mode_t;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [2:0] pull_up;
      logic [2:0] pull_down;
   } bias_out_t;
endpackage : wake_pkg

// [hw/wake_filter.sv]
// Module: per-input synchroniser and restart-on-crossing deglitch filter
`timescale 1ns/10ps
`default_nettype none
module wake_filter #(
   parameter int unsigned CNT_W = 13
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Pin and control
   input  wire logic             pin_async,
   input  wire logic             sense_open,
   input  wire logic [CNT_W-1:0] filt_cycles,
   // Results
   output logic                  level,
   output logic                  edge_pulse
);
   logic             s1_reg;
   logic             s2_reg;
   logic             s3_reg;
   logic             cand_reg;
   logic             level_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic             edge_reg;
   wire              stable   = (s2_reg == s3_reg);
   wire              crossed  = stable && (s3_reg != cand_reg);
   wire              done     = (cnt_reg == filt_cycles) && (cand_reg != level_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Counter restarts on every agreed crossing, so a bounce back cancels the edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cand_reg  <= 1'b0;
         level_reg <= 1'b0;
         cnt_reg   <= '0;
         edge_reg  <= 1'b0;
      end else begin
         edge_reg <= 1'b0;
         if (!sense_open) begin
            cnt_reg <= '0;
         end else if (crossed) begin
            cand_reg <= s3_reg;
            cnt_reg  <= CNT_W'(1);
         end else if (done) begin
            level_reg <= cand_reg;
            edge_reg  <= 1'b1;
         end else if (cand_reg != level_reg) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
         end
      end
   end

   assign level      = level_reg;
   assign edge_pulse = edge_reg;
endmodule : wake_filter
`default_nettype wire

// [tb/wake_switch_model.sv]
// Partner model: wake pin contacts with device bias sources and floating pins
`timescale 1ns/10ps
`default_nettype none
module wake_switch_model (
   // Clock
   input  wire logic       pclk,
   // Contacts set by the bench
   input  wire logic [4:0] contact_level,
   input  wire logic [4:0] contact_open,
   // Bias sources from the device
   input  wire logic [2:0] pull_up_en,
   input  wire logic [2:0] pull_down_en,
   // Pins
   output logic [2:0]      hv_wake_pin,
   output logic [1:0]      alt_output_pins
);
   logic [4:0] float_pat = 5'h15;
   logic [4:0] pin;
   wire  logic [4:0] up = {2'h0, pull_up_en};
   wire  logic [4:0] dn = {2'h0, pull_down_en};
   // An open unbiased pin wanders so it never looks like a clean level
   always @(posedge pclk) begin
      float_pat <= ~float_pat;
   end
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pin[i] = !contact_open[i] ? contact_level[i] : up[i] ? 1'h1 : dn[i] ? 1'h0 : float_pat[i];
      end
   end
   assign hv_wake_pin     = pin[2:0];
   assign alt_output_pins = pin[4:3];
endmodule : wake_switch_model
`default_nettype wire

// [tb/test_wake_input_detector.sv]
// Testbench: APB driven checks of the wake input detector
`timescale 1ns/10ps
`default_nettype none
module test_wake_input_detector;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  hv_wake_pin;
   logic [1:0]  alt_output_pins;
   logic [2:0]  pull_up_en;
   logic [2:0]  pull_down_en;
   logic        wake_request;
   logic        irq;
   logic [4:0]  contact_level = 5'h0;
   logic [4:0]  contact_open = 5'h0;
   logic [31:0] rd;
   logic        err;
   int          num_errors = 0;
   int          comparisons = 0;

   always #5 pclk = ~pclk;

   // Short counts keep the run brief; timer two runs at twice the period
   wake_input_detector #(.FILT_SHORT(8), .FILT_LONG(20), .PERIOD(50), .ON_TIME(10)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hv_wake_pin(hv_wake_pin), .alt_output_pins(alt_output_pins), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .wake_request(wake_request), .irq(irq));

   wake_switch_model u_model (
      .pclk(pclk), .contact_level(contact_level), .contact_open(contact_open),
      .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
      .hv_wake_pin(hv_wake_pin), .alt_output_pins(alt_output_pins));

   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Entered and left in the time step of a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Pready is looked at only as sampled at a rising edge, request held until then
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      check(32'(n < 20), 32'h1);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      check(rd, exp);
   endtask : rchk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   initial begin
      #200000;
      num_errors++;
      finish_test();
   end

   initial begin
      cyc(12);
      presetn <= 1'h1;
      cyc(1);
      rchk(wake_pkg::OFS_ENABLE_CTRL, 32'h0);
      rchk(wake_pkg::OFS_DETECT_CTRL, 32'h0);
      rchk(wake_pkg::OFS_BIAS_CTRL, 32'h0);
      apb(1'h0, 12'hFFC, 32'h0);
      check(32'({err, rd[0]}), 32'h2);
      wr(wake_pkg::OFS_BIAS_CTRL, 32'h24);
      check(32'({pull_up_en, pull_down_en}), 32'h22);
      wr(wake_pkg::OFS_IRQ_ENABLE, 32'h3);
      wr(wake_pkg::OFS_ENABLE_CTRL, 32'h3);
      wr(wake_pkg::OFS_DETECT_CTRL, 32'h04);
      wr(wake_pkg::OFS_BIAS_CTRL, 32'h3F);
      check(32'({pull_up_en, pull_down_en}), 32'h07);
      // Glitches shorter than the filter must be swallowed
      contact_level <= 5'h05;
      cyc(5);
      contact_level <= 5'h00;
      cyc(30);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h0);
      contact_level <= 5'h02;
      cyc(14);
      contact_level <= 5'h00;
      cyc(40);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h0);
      check(32'(irq), 32'h0);
      // Rising edges: pin2 is not a wake source but its level still shows
      contact_level <= 5'h07;
      cyc(30);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h3);
      rchk(wake_pkg::OFS_LEVEL_STATUS, 32'h7);
      check(32'({irq, wake_request}), 32'h2);
      check(32'({pull_up_en, pull_down_en}), 32'h38);
      rchk(wake_pkg::OFS_IRQ_STATUS, 32'h1);
      cyc(20);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h3);
      wr(wake_pkg::OFS_SRC_CLEAR, 32'h7);
      wr(wake_pkg::OFS_IRQ_CLEAR, 32'h3);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h0);
      check(32'(irq), 32'h0);
      // Falling edges count too
      contact_level <= 5'h00;
      cyc(30);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h3);
      rchk(wake_pkg::OFS_LEVEL_STATUS, 32'h0);
      // Sleep: wake request instead of the Normal interrupt, mask then unmask
      wr(wake_pkg::OFS_SRC_CLEAR, 32'h7);
      wr(wake_pkg::OFS_IRQ_CLEAR, 32'h3);
      wr(wake_pkg::OFS_MODE_CTRL, 32'h2);
      wr(wake_pkg::OFS_IRQ_ENABLE, 32'h1);
      contact_level <= 5'h01;
      cyc(30);
      check(32'({irq, wake_request}), 32'h1);
      rchk(wake_pkg::OFS_IRQ_STATUS, 32'h2);
      wr(wake_pkg::OFS_IRQ_ENABLE, 32'h2);
      check(32'(irq), 32'h1);
      wr(wake_pkg::OFS_IRQ_CLEAR, 32'h2);
      check(32'({irq, wake_request}), 32'h0);
      // Alternate pins in Fail-Safe: only the enabled one reports, in its own register, and wakes
      wr(wake_pkg::OFS_MODE_CTRL, 32'h7);
      contact_level <= 5'h19;
      cyc(30);
      rchk(wake_pkg::OFS_ALT_STATUS, 32'h1);
      check(32'({irq, wake_request}), 32'h3);
      // Cyclic sense on both timers in Stop; both cyclic pins set their source flags
      wr(wake_pkg::OFS_SRC_CLEAR, 32'h1F);
      wr(wake_pkg::OFS_MODE_CTRL, 32'h5);
      wr(wake_pkg::OFS_DETECT_CTRL, 32'h0E);
      contact_level <= 5'h1A;
      cyc(250);
      rchk(wake_pkg::OFS_SRC_STATUS, 32'h3);
      rchk(wake_pkg::OFS_IRQ_STATUS, 32'h3);
      // Open contact on pin2 is held high by its pull-up alone
      wr(wake_pkg::OFS_BIAS_CTRL, 32'h2F);
      contact_open <= 5'h04;
      cyc(20);
      check(32'({pull_up_en, pull_down_en}), 32'h31);
      rchk(wake_pkg::OFS_LEVEL_STATUS, 32'h6);
      finish_test();
   end
endmodule : test_wake_input_detector
`default_nettype wire
